// file: pkg/gear_cam_pkg.sv
// shared constants for the synchronised gear and cam following block
`default_nettype none
package gear_cam_pkg;
    // ------------------------------------------------------------------
    // operand table codes
    // ------------------------------------------------------------------
    localparam logic [7:0] FUNC_GEAR     = 8'h01;
    localparam logic [7:0] FUNC_CAM      = 8'h02;
    localparam logic [2:0] AXIS_NONE     = 3'h0;
    localparam logic [2:0] AXIS_LAST     = 3'h4;
    localparam int         AXIS_COUNT    = 4;
    localparam int         AXIS_CODE_MSB = 2;
    localparam int         SRC_CMD_BIT   = 4;
    localparam logic       HW_SEL_SYNC   = 1'b1;

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    localparam logic [1:0] MODE_STOP      = 2'h0;
    localparam logic [1:0] MODE_PASS      = 2'h1;
    localparam logic [1:0] MODE_INPOS_OFF = 2'h2;

    // ------------------------------------------------------------------
    // error flag positions
    // ------------------------------------------------------------------
    localparam int ERR_W        = 9;
    localparam int ERR_CW_OT    = 0;
    localparam int ERR_CCW_OT   = 1;
    localparam int ERR_ESTOP    = 2;
    localparam int ERR_ALARM    = 3;
    localparam int ERR_OVERFLOW = 4;
    localparam int ERR_SOFT_LIM = 5;
    localparam int ERR_REFUSED  = 6;
    localparam int ERR_BUSY     = 7;
    localparam int ERR_SCOPE    = 8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int CTRL_CYCLE_NS   = 2000000;
    localparam int CTRL_CYCLE_CLKS = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_GEAR,
        ST_CAM
    } follow_state_t;
endpackage : gear_cam_pkg
`default_nettype wire

// file: hdl/axis_gear_cam_sync.sv
// gear and cam following for one operating axis
`timescale 1ns/1ps
`default_nettype none
module axis_gear_cam_sync
    import gear_cam_pkg::*;
#(
    parameter int CYCLE_CLKS = CTRL_CYCLE_CLKS,
    parameter int SPD_W      = 16,
    parameter int POS_W      = 32,
    parameter int CAM_AW     = 6,
    parameter int PH_W       = 12,
    parameter int TASKS      = 2
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rstn,
    input  wire logic                       start_cmd,
    input  wire logic [2:0]                 op_axis,
    input  wire logic [$clog2(TASKS)-1:0]   task_sel,
    input  wire logic [1:0]                 op_mode,
    input  wire logic [7:0]                 func_word,
    input  wire logic [7:0]                 input_axis_word,
    input  wire logic [7:0]                 integ_axis_word,
    input  wire logic signed [SPD_W-1:0]    gear_num,
    input  wire logic [SPD_W-1:0]           gear_den,
    input  wire logic                       cancel_cmd,
    input  wire logic                       optional_end_cmd,
    input  wire logic                       forced_end,
    input  wire logic                       pause_req,
    input  wire logic                       servo_unlock,
    input  wire logic                       servo_error,
    input  wire logic [AXIS_COUNT-1:0]      limit_cw,
    input  wire logic [AXIS_COUNT-1:0]      limit_ccw,
    input  wire logic                       estop,
    input  wire logic [AXIS_COUNT-1:0]      driver_alarm,
    input  wire logic                       system_error,
    input  wire logic [TASKS-1:0]           task_error,
    input  wire logic [AXIS_COUNT-1:0]      axis_error,
    input  wire logic signed [SPD_W-1:0]    handwheel_pulse_input,
    input  wire logic signed [SPD_W-1:0]    sync_encoder_pulses,
    input  wire logic                       hw_sync_sel,
    input  wire logic [AXIS_COUNT*SPD_W-1:0] axis_enc_speed,
    input  wire logic [AXIS_COUNT*SPD_W-1:0] axis_cmd_speed,
    input  wire logic [SPD_W-1:0]           max_feed,
    input  wire logic [AXIS_COUNT-1:0]      soft_limit_en,
    input  wire logic [AXIS_COUNT-1:0]      origin_done,
    input  wire logic signed [POS_W-1:0]    soft_limit_pos,
    input  wire logic signed [POS_W-1:0]    soft_limit_neg,
    input  wire logic signed [POS_W-1:0]    present_pos,
    input  wire logic [SPD_W-1:0]           backlash,
    input  wire logic                       cam_wr_en,
    input  wire logic [CAM_AW-1:0]          cam_wr_addr,
    input  wire logic signed [POS_W-1:0]    cam_wr_data,
    input  wire logic                       err_clear,
    output logic signed [POS_W-1:0]         cmd_delta,
    output logic                            cmd_valid,
    output logic                            axis_operating,
    output logic                            positioning_done,
    output logic                            op_complete,
    output logic                            override_disable,
    output logic                            inpos_check_req,
    output logic                            gear_active,
    output logic                            cam_active,
    output logic [ERR_W-1:0]                err_flags
);
    localparam int ACC_W = 2 * SPD_W + 16;
    localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
    localparam int DEPTH = 2 ** CAM_AW;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic axis_bit(input logic [AXIS_COUNT-1:0] vec, input logic [2:0] code);
        axis_bit = 1'b0;
        for (int i = 0; i < AXIS_COUNT; i++) begin
            if (code == 3'(i + 1)) begin
                axis_bit = vec[i];
            end
        end
    endfunction : axis_bit

    function automatic logic signed [SPD_W-1:0] axis_speed(input logic [AXIS_COUNT*SPD_W-1:0] bus,
                                                            input logic [2:0] code);
        axis_speed = '0;
        for (int i = 0; i < AXIS_COUNT; i++) begin
            if (code == 3'(i + 1)) begin
                axis_speed = bus[i*SPD_W +: SPD_W];
            end
        end
    endfunction : axis_speed

    function automatic logic axis_valid(input logic [2:0] code);
        axis_valid = (code != AXIS_NONE) && (code <= AXIS_LAST);
    endfunction : axis_valid

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    follow_state_t                 state_reg;
    logic [CNT_W-1:0]              tick_cnt_reg;
    logic                          tick;
    logic [2:0]                    op_axis_reg;
    logic [7:0]                    in_word_reg;
    logic [2:0]                    integ_reg;
    logic [1:0]                    mode_reg;
    logic [$clog2(TASKS)-1:0]      task_reg;
    logic signed [ACC_W-1:0]       rem_reg;
    logic                          dir_pos_reg;
    logic [PH_W-1:0]               phase_reg;
    logic signed [POS_W-1:0]       rev_off_reg;
    logic signed [POS_W-1:0]       cam_pos_reg;
    logic signed [POS_W-1:0]       cam_table [DEPTH];

    // ------------------------------------------------------------------
    // control cycle divider
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end
    assign tick = (tick_cnt_reg == CNT_W'(CYCLE_CLKS - 1));

    // ------------------------------------------------------------------
    // cam table storage
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (cam_wr_en) begin
            cam_table[cam_wr_addr] <= cam_wr_data;
        end
    end

    // ------------------------------------------------------------------
    // start checks and halt causes
    // ------------------------------------------------------------------
    logic       running;
    logic [2:0] in_code_new;
    logic [2:0] integ_new;
    logic       axes_ok;
    logic       func_ok;
    logic       accept;
    logic       hit_cw;
    logic       hit_ccw;
    logic       hit_alarm;
    logic       hit_scope;
    logic       hard_halt;
    logic       inpos_mode_ev;
    logic       inpos_always_ev;

    assign running     = (state_reg != ST_IDLE);
    assign in_code_new = input_axis_word[AXIS_CODE_MSB:0];
    assign integ_new   = integ_axis_word[AXIS_CODE_MSB:0];
    assign func_ok     = (func_word == FUNC_GEAR) || (func_word == FUNC_CAM);
    // axis code 0 means handwheel or sync encoder (per hw_sync_sel) for input and none for integration
    assign axes_ok = axis_valid(op_axis)
                  && (in_code_new <= AXIS_LAST) && (integ_new <= AXIS_LAST)
                  && (in_code_new != op_axis) && (integ_new != op_axis)
                  && (in_code_new != integ_new || in_code_new == AXIS_NONE);
    assign accept = start_cmd && !running && func_ok && axes_ok;

    assign hit_cw    = axis_bit(limit_cw, op_axis_reg);
    assign hit_ccw   = axis_bit(limit_ccw, op_axis_reg);
    assign hit_alarm = axis_bit(driver_alarm, op_axis_reg);
    assign hit_scope = system_error
                    || task_error[task_reg]
                    || axis_bit(axis_error, op_axis_reg);
    assign hard_halt = running && (hit_cw || hit_ccw || estop || hit_alarm || hit_scope);

    assign inpos_mode_ev   = running && (cancel_cmd || optional_end_cmd);
    assign inpos_always_ev = running && (forced_end || pause_req || servo_unlock || servo_error);

    // ------------------------------------------------------------------
    // per-cycle command computation
    // ------------------------------------------------------------------
    logic signed [SPD_W-1:0]  in_speed;
    logic signed [SPD_W-1:0]  integ_speed;
    logic signed [ACC_W-1:0]  total;
    logic signed [ACC_W-1:0]  quot;
    logic signed [ACC_W-1:0]  den_s;
    logic signed [ACC_W-1:0]  rem_next;
    logic signed [PH_W+1:0]   ph_sum;
    logic [PH_W-1:0]          ph_next;
    logic signed [POS_W-1:0]  stroke;
    logic signed [POS_W-1:0]  rev_off_next;
    logic signed [POS_W-1:0]  cam_target;
    logic signed [POS_W-1:0]  follow;
    logic signed [POS_W-1:0]  cmd;
    logic [POS_W-1:0]         cmd_mag;
    logic signed [POS_W-1:0]  predicted;
    logic                     overflow;
    logic                     soft_hit;
    logic signed [POS_W-1:0]  lash;

    always_comb begin
        // handwheel feeds through unscaled or the sync encoder, per setting
        if (in_word_reg[AXIS_CODE_MSB:0] == AXIS_NONE) begin
            in_speed = (hw_sync_sel == HW_SEL_SYNC) ? sync_encoder_pulses : handwheel_pulse_input;
        end else if (in_word_reg[SRC_CMD_BIT]) begin
            in_speed = axis_speed(axis_cmd_speed, in_word_reg[AXIS_CODE_MSB:0]);
        end else begin
            in_speed = axis_speed(axis_enc_speed, in_word_reg[AXIS_CODE_MSB:0]);
        end
        integ_speed = axis_speed(axis_cmd_speed, integ_reg);
    end

    always_comb begin
        // ratio works on raw pulses; unit scaling never enters here
        den_s = ACC_W'($signed({1'b0, gear_den}));
        total = rem_reg + ACC_W'(in_speed * gear_num);
        quot  = (gear_den == '0) ? '0 : total / den_s;
        // remainder carried so fractional pulses are never lost
        rem_next = (gear_den == '0) ? '0 : total - ACC_W'(quot * den_s);
    end

    always_comb begin
        ph_sum  = $signed({2'b00, phase_reg}) + (PH_W+2)'(in_speed);
        ph_next = ph_sum[PH_W-1:0];
        // end-to-end difference is zero for reciprocating, the feed pitch otherwise
        stroke = cam_table[DEPTH-1] - cam_table[0];
        if (ph_sum[PH_W+1]) begin
            rev_off_next = rev_off_reg - stroke;
        end else if (ph_sum[PH_W]) begin
            rev_off_next = rev_off_reg + stroke;
        end else begin
            rev_off_next = rev_off_reg;
        end
        cam_target = cam_table[ph_next[PH_W-1 -: CAM_AW]] + rev_off_next;
    end

    always_comb begin
        follow    = (state_reg == ST_CAM) ? (cam_target - cam_pos_reg) : POS_W'(quot);
        cmd       = follow + POS_W'(integ_speed);
        cmd_mag   = cmd[POS_W-1] ? POS_W'(-cmd) : cmd;
        overflow  = cmd_mag > POS_W'(max_feed);
        predicted = present_pos + cmd;
        soft_hit  = axis_bit(soft_limit_en, op_axis_reg) && axis_bit(origin_done, op_axis_reg)
                 && (predicted > soft_limit_pos || predicted < soft_limit_neg);
        lash = '0;
        if (cmd > 0 && !dir_pos_reg) begin
            lash = POS_W'(backlash);
        end else if (cmd < 0 && dir_pos_reg) begin
            lash = -POS_W'(backlash);
        end
    end

    logic step_ok;
    assign step_ok = running && tick && !hard_halt && !overflow && !soft_hit
                  && !inpos_mode_ev && !inpos_always_ev;

    // ------------------------------------------------------------------
    // following state
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg <= (func_word == FUNC_CAM) ? ST_CAM : ST_GEAR;
                    end
                end
                ST_GEAR, ST_CAM: begin
                    // every stop is immediate: no ramp, output goes to zero
                    if (hard_halt || inpos_mode_ev || inpos_always_ev) begin
                        state_reg <= ST_IDLE;
                    end else if (tick && (overflow || soft_hit)) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            op_axis_reg <= AXIS_NONE;
            in_word_reg <= '0;
            integ_reg   <= AXIS_NONE;
            mode_reg    <= MODE_STOP;
            task_reg    <= '0;
        end else if (accept) begin
            op_axis_reg <= op_axis;
            in_word_reg <= input_axis_word;
            integ_reg   <= integ_new;
            mode_reg    <= op_mode;
            task_reg    <= task_sel;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rem_reg     <= '0;
            phase_reg   <= '0;
            rev_off_reg <= '0;
            cam_pos_reg <= '0;
        end else if (accept) begin
            rem_reg     <= '0;
            phase_reg   <= '0;
            rev_off_reg <= '0;
            cam_pos_reg <= cam_table[0];
        end else if (step_ok) begin
            rem_reg     <= rem_next;
            phase_reg   <= ph_next;
            rev_off_reg <= rev_off_next;
            cam_pos_reg <= cam_target;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dir_pos_reg <= 1'b1;
        end else if (step_ok && cmd != 0) begin
            dir_pos_reg <= (cmd > 0);
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_delta <= '0;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= step_ok;
            cmd_delta <= step_ok ? (cmd + lash) : '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            op_complete     <= 1'b0;
            inpos_check_req <= 1'b0;
        end else begin
            // stop mode holds the program on this block indefinitely
            op_complete     <= accept && (op_mode != MODE_STOP);
            inpos_check_req <= inpos_always_ev
                            || (inpos_mode_ev && mode_reg != MODE_INPOS_OFF);
        end
    end

    assign axis_operating   = running;
    assign positioning_done = !running;
    assign override_disable = (state_reg == ST_GEAR);
    assign gear_active      = (state_reg == ST_GEAR);
    assign cam_active       = (state_reg == ST_CAM);

    // ------------------------------------------------------------------
    // sticky error flags, a new event beats a same-cycle clear
    // ------------------------------------------------------------------
    logic [ERR_W-1:0] err_set;
    always_comb begin
        err_set               = '0;
        err_set[ERR_CW_OT]    = running && hit_cw;
        err_set[ERR_CCW_OT]   = running && hit_ccw;
        err_set[ERR_ESTOP]    = running && estop;
        err_set[ERR_ALARM]    = running && hit_alarm;
        err_set[ERR_OVERFLOW] = running && tick && overflow;
        err_set[ERR_SOFT_LIM] = running && tick && soft_hit;
        err_set[ERR_REFUSED]  = start_cmd && !running && !(func_ok && axes_ok);
        err_set[ERR_BUSY]     = start_cmd && running;
        err_set[ERR_SCOPE]    = running && hit_scope;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            err_flags <= '0;
        end else begin
            err_flags <= (err_clear ? '0 : err_flags) | err_set;
        end
    end
endmodule : axis_gear_cam_sync
`default_nettype wire

// file: tb/axis_gear_cam_sync_props.sv
// assertion checker for the gear and cam following block
`timescale 1ns/1ps
`default_nettype none
module axis_gear_cam_sync_props
    import gear_cam_pkg::*;
(
    input wire logic               ref_clk, rstn, estop, system_error, forced_end, cancel_cmd, cmd_valid,
    input wire logic               axis_operating, op_complete, override_disable, inpos_check_req,
    input wire logic               gear_active, cam_active,
    input wire logic [1:0]         op_mode,
    input wire logic [2:0]         op_axis,
    input wire logic [3:0]         limit_cw, driver_alarm,
    input wire logic [15:0]        max_feed, backlash,
    input wire logic signed [31:0] cmd_delta,
    input wire logic [8:0]         err_flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // bench holds op_axis and op_mode steady while following runs
    wire logic [3:0]  opm = 4'h1 << (op_axis - 3'h1);
    wire logic [31:0] mag = cmd_delta[31] ? -cmd_delta : cmd_delta;
    a_limit_halt: assert property (axis_operating && |(limit_cw & opm) |=> !axis_operating && err_flags[ERR_CW_OT])
        else $error("limit input did not halt axis");
    a_estop_halt: assert property (axis_operating && estop |=> !axis_operating && err_flags[ERR_ESTOP])
        else $error("emergency stop did not halt axis");
    a_alarm_halt: assert property (axis_operating && |(driver_alarm & opm) |=> !axis_operating && err_flags[ERR_ALARM])
        else $error("driver alarm did not halt axis");
    a_system_halt: assert property (axis_operating && system_error |=> !axis_operating && err_flags[ERR_SCOPE])
        else $error("system error did not halt axis");
    a_stop_nodone: assert property (op_complete |-> $past(op_mode) != MODE_STOP)
        else $error("completion seen in stop mode");
    a_gear_override: assert property (gear_active |-> override_disable)
        else $error("override left enabled");
    a_feed_bound: assert property (cmd_valid |-> mag <= {16'h0, max_feed} + {16'h0, backlash})
        else $error("output step above feed limit");
    a_forced_inpos: assert property (axis_operating && forced_end |=> inpos_check_req)
        else $error("forced end without in-position check");
    a_cancel_noinpos: assert property (axis_operating && cancel_cmd && !forced_end && op_mode == MODE_INPOS_OFF |=> !inpos_check_req)
        else $error("cancel checked position in check-off mode");
    a_single_mode: assert property (!(gear_active && cam_active))
        else $error("gear and cam active together");
    a_step_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("step strobe longer than one cycle");
    cover property (cmd_valid);
    cover property (op_complete);
    cover property (inpos_check_req);
    cover property (cam_active && cmd_valid);
endmodule : axis_gear_cam_sync_props
bind axis_gear_cam_sync axis_gear_cam_sync_props u_axis_gear_cam_sync_props (.*);
`default_nettype wire

// file: tb/servo_side_model.sv
// drives, encoders and handwheel seen by the following block
`timescale 1ns/1ps
`default_nettype none
module servo_side_model (
    input wire logic               ref_clk, rstn, alarm_req,
    input wire logic signed [15:0] rate,
    output logic signed [15:0]     handwheel_pulse_input, sync_encoder_pulses,
    output logic [63:0]            axis_enc_speed, axis_cmd_speed,
    output logic [3:0]             driver_alarm
);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {handwheel_pulse_input, sync_encoder_pulses, axis_enc_speed, axis_cmd_speed, driver_alarm} <= '0;
        end else begin
            handwheel_pulse_input <= rate;
            // encoder differs so a wrong source selection shows up
            sync_encoder_pulses   <= -rate;
            axis_enc_speed        <= {4{~rate}};
            axis_cmd_speed        <= {4{rate}};
            driver_alarm          <= {3'h0, alarm_req};
        end
    end
endmodule : servo_side_model
`default_nettype wire

// file: tb/axis_gear_cam_sync_tb.sv
// self-checking bench for the gear and cam following block
`timescale 1ns/1ps
`default_nettype none
module axis_gear_cam_sync_tb;
    import gear_cam_pkg::*;
    logic ref_clk = 0, rstn = 0, start_cmd = 0, cancel_cmd = 0, optional_end_cmd = 0, forced_end = 0, pause_req = 0;
    logic servo_unlock = 0, servo_error = 0, estop = 0, system_error = 0, hw_sync_sel = 0, cam_wr_en = 0;
    logic err_clear = 0, alarm_req = 0, task_sel = 0;
    logic [2:0] op_axis = 3'h1;
    logic [1:0] op_mode = MODE_PASS, task_error = '0;
    logic [7:0] func_word = FUNC_GEAR, input_axis_word = '0, integ_axis_word = '0;
    logic signed [15:0] gear_num = 16'sh3, rate = 16'sh4, handwheel_pulse_input, sync_encoder_pulses;
    logic [15:0] gear_den = 16'h2, max_feed = 16'h40, backlash = 16'h5; // ratio in pulses
    logic [3:0] limit_cw = '0, limit_ccw = '0, axis_error = '0, soft_limit_en = '0, origin_done = '0, driver_alarm;
    logic signed [31:0] soft_limit_pos = 32'sh1000, soft_limit_neg = -32'sh1000, present_pos = '0;
    logic signed [31:0] cam_wr_data = '0, cmd_delta;
    logic [5:0] cam_wr_addr = '0;
    logic [63:0] axis_enc_speed, axis_cmd_speed;
    logic cmd_valid, axis_operating, positioning_done, op_complete, override_disable, inpos_check_req;
    logic gear_active, cam_active;
    logic [8:0] err_flags;
    int bad_count = 0, checks = 0;
    int eb[6] = '{ERR_CW_OT, ERR_CCW_OT, ERR_ALARM, ERR_SCOPE, ERR_SCOPE, ERR_SCOPE};

    // short control cycle keeps the run brief
    axis_gear_cam_sync #(.CYCLE_CLKS(10)) u_axis_gear_cam_sync (.*);
    servo_side_model u_servo_side_model (.*);

    initial forever #20 ref_clk = ~ref_clk;

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic start(input logic [7:0] iw);
        input_axis_word = iw; // words stand through the start edge
        pulse(start_cmd);
    endtask : start
    task automatic wait_step;
        cyc(1);
        for (int i = 0; i < 30 && cmd_valid !== 1'b1; i++) cyc(1);
    endtask : wait_step
    task automatic stop_by(ref logic s, input logic [1:0] exp);
        start(8'h0);
        pulse(s);
        chk({axis_operating, inpos_check_req}, exp);
    endtask : stop_by
    task automatic finish_test;
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100us;
        $display("ERROR %0t: watchdog expired", $time);
        bad_count++;
        finish_test();
    end

    initial begin
        cyc(6);
        rstn = 1'b1;
        start(8'h0);
        chk({op_complete, gear_active, override_disable, axis_operating, positioning_done}, 5'b11110);
        cyc(1);
        func_word = FUNC_CAM;
        start(8'h2);
        chk({cam_active, err_flags[ERR_BUSY]}, 2'b01);
        func_word = FUNC_GEAR;
        wait_step();
        chk(cmd_delta, 32'h6);
        rate = -16'sh4;
        wait_step();
        chk(cmd_delta, -32'shB);
        // sync encoder shows the negated rate, so the input is +4 again
        hw_sync_sel = 1'b1;
        gear_num = 16'sh5;
        wait_step();
        chk(cmd_delta, 32'hF);
        task_error = 2'h2;
        axis_error = 4'h2;
        cyc(2);
        chk(axis_operating, 1'b1);
        {task_error, axis_error} = '0;
        pulse(estop);
        chk({axis_operating, err_flags[ERR_ESTOP]}, 2'b01);
        pulse(err_clear);
        for (int i = 0; i < 6; i++) begin
            start(8'h0);
            case (i)
                0: limit_cw = 4'h1;
                1: limit_ccw = 4'h1;
                2: alarm_req = 1'b1;
                3: system_error = 1'b1;
                4: task_error = 2'h1;
                default: axis_error = 4'h1;
            endcase
            cyc(2);
            {limit_cw, limit_ccw, alarm_req, system_error, task_error, axis_error} = '0;
            chk({axis_operating, err_flags[eb[i]]}, 2'b01);
            pulse(err_clear);
        end
        op_mode = MODE_STOP;
        start(8'h0);
        chk(op_complete, 1'b0);
        pulse(cancel_cmd);
        chk({axis_operating, inpos_check_req}, 2'b01);
        op_mode = MODE_INPOS_OFF;
        start(8'h0);
        pulse(cancel_cmd);
        chk(inpos_check_req, 1'b0);
        start(8'h0);
        pulse(forced_end);
        chk({axis_operating, inpos_check_req}, 2'b01);
        stop_by(optional_end_cmd, 2'b00);
        stop_by(pause_req, 2'b01);
        stop_by(servo_unlock, 2'b01);
        stop_by(servo_error, 2'b01);
        start(8'h1);
        chk({gear_active, err_flags[ERR_REFUSED]}, 2'b01);
        pulse(err_clear);
        max_feed = 16'h5;
        start(8'h0);
        cyc(15);
        chk({axis_operating, err_flags[ERR_OVERFLOW]}, 2'b01);
        max_feed = 16'h40;
        {soft_limit_en, present_pos} = {4'h1, 32'sh1000};
        start(8'h0);
        wait_step();
        chk(cmd_valid, 1'b1);
        origin_done = 4'h1;
        cyc(15);
        chk({axis_operating, err_flags[ERR_SOFT_LIM]}, 2'b01);
        // feed cam rising one per slot: a backward wrap must carry the pitch
        cam_wr_en = 1'b1;
        for (int k = 0; k < 64; k++) begin
            cam_wr_addr = 6'(k);
            cam_wr_data = k;
            cyc(1);
        end
        cam_wr_en = 1'b0;
        present_pos = '0;
        rate = 16'sh40;
        func_word = FUNC_CAM;
        start(8'h12);
        wait_step();
        chk(cmd_delta, 32'h1);
        rate = -16'sh80;
        wait_step();
        chk(cmd_delta, -32'sh6);
        finish_test();
    end
endmodule : axis_gear_cam_sync_tb
`default_nettype wire
